// ==== logic/mode_table.v ====
`default_nettype none

// ----------------------------------------------------------------
// basic clock mode table
// ----------------------------------------------------------------
`include "reset_clock_mode_decoder_consts.vh"

module mode_table (
    input wire [`MODE_W-1:0] i_code,
    output wire o_input_is_66,
    output wire [`IN_KHZ_W-1:0] o_input_khz,
    output wire [`FACTOR_W-1:0] o_comm_factor_x2,
    output wire [`FACTOR_W-1:0] o_core_factor_x2
);
    wire is_66;
    wire comm_hi;
    wire core_hi;

    assign is_66 = i_code[`MODE_CLASS_BIT];
    assign comm_hi = i_code[`MODE_COMM_BIT];
    assign core_hi = i_code[`MODE_CORE_BIT];

    assign o_input_is_66 = is_66;
    assign o_input_khz = is_66 ? `IN_KHZ_66 : `IN_KHZ_33;

    // 000/001 -> 3, 010/011 -> 4 at 33 MHz; 100/101 -> 2, 110/111 -> 2.5 at 66 MHz
    assign o_comm_factor_x2 = is_66 ? (comm_hi ? `COMM_X2_66_HI : `COMM_X2_66_LO) :
                                      (comm_hi ? `COMM_X2_33_HI : `COMM_X2_33_LO);

    // x00/x10 -> 4 or 2.5, x01/x11 -> 5 or 3 depending on the class
    assign o_core_factor_x2 = is_66 ? (core_hi ? `CORE_X2_66_HI : `CORE_X2_66_LO) :
                                      (core_hi ? `CORE_X2_33_HI : `CORE_X2_33_LO);
endmodule

`default_nettype wire

// ==== logic/reset_clock_mode_decoder.v ====
// What this block does
// - sample the three mode-select pins while hard reset is asserted
// - three-bit code picks exactly one of eight basic clock configurations
// - comm processor factor 3,3,4,4 at 33 MHz; 2,2,2.5,2.5 at 66 MHz
// - core factor 4,5,4,5 for codes 0-3; 2.5,3,2.5,3 for codes 4-7
// - extended config combines four data-bus bits with the mode-select pins
// - new configuration takes effect only when power-on and hard reset are asserted together, not under either alone
`default_nettype none

`include "reset_clock_mode_decoder_consts.vh"

module reset_clock_mode_decoder (
    input wire i_clk_sys,
    input wire i_rstn,
    input wire i_por_n,
    input wire i_hard_reset_in_n,
    input wire i_reset_config_select,
    input wire [`MODE_W-1:0] i_clock_mode_select_pins,
    input wire [`MODE_HI_W-1:0] i_cfg_word_mode_bits,
    output wire [`FULL_MODE_W-1:0] o_active_mode,
    output wire o_active_extended,
    output wire o_factors_valid,
    output wire o_input_is_66,
    output wire [`IN_KHZ_W-1:0] o_input_khz,
    output wire [`FACTOR_W-1:0] o_comm_factor_x2,
    output wire [`FACTOR_W-1:0] o_core_factor_x2,
    output wire [`FREQ_W-1:0] o_comm_khz,
    output wire [`FREQ_W-1:0] o_core_khz,
    output wire [`FULL_MODE_W-1:0] o_sampled_mode,
    output wire o_change_pending,
    output wire o_config_valid,
    output wire o_config_applied
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // product of input kHz and a doubled factor, halved back
    function [`FREQ_W-1:0] scaled_khz;
        input [`IN_KHZ_W-1:0] in_khz;
        input [`FACTOR_W-1:0] factor_x2;
        reg [`PROD_W-1:0] prod;
        begin
            prod = {{(`PROD_W-`IN_KHZ_W){1'b0}}, in_khz} *
                   {{(`PROD_W-`FACTOR_W){1'b0}}, factor_x2};
            scaled_khz = prod[`FREQ_W:1];
        end
    endfunction

    // ----------------------------------------------------------------
    // reset qualifiers
    // ----------------------------------------------------------------
    wire hard_reset_active;
    wire por_active;
    wire load_now;

    assign hard_reset_active = ~i_hard_reset_in_n;
    assign por_active = ~i_por_n;
    // power-on reset loads only together with hard reset; a hard reset on its own never loads
    assign load_now = por_active & hard_reset_active;

    // ----------------------------------------------------------------
    // live decode of the pins
    // ----------------------------------------------------------------
    wire [`MODE_HI_W-1:0] live_hi;
    wire [`FULL_MODE_W-1:0] live_mode;
    wire live_is_66;
    wire [`IN_KHZ_W-1:0] live_khz;
    wire [`FACTOR_W-1:0] live_comm_x2;
    wire [`FACTOR_W-1:0] live_core_x2;

    // the upper bits count only when the extended sequence is selected
    assign live_hi = i_reset_config_select ? i_cfg_word_mode_bits : `RST_MODE_HI;
    assign live_mode = {live_hi, i_clock_mode_select_pins};

    mode_table u_mode_table (
        .i_code(i_clock_mode_select_pins),
        .o_input_is_66(live_is_66),
        .o_input_khz(live_khz),
        .o_comm_factor_x2(live_comm_x2),
        .o_core_factor_x2(live_core_x2)
    );

    // ----------------------------------------------------------------
    // sampling during hard reset
    // ----------------------------------------------------------------
    reg [`FULL_MODE_W-1:0] sampled_mode_ff;
    reg [`FULL_MODE_W-1:0] nxt_sampled_mode;

    always @* begin
        nxt_sampled_mode = sampled_mode_ff;
        if (hard_reset_active) begin
            nxt_sampled_mode = live_mode;
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sampled_mode_ff <= `RST_FULL_MODE;
        end else begin
            sampled_mode_ff <= nxt_sampled_mode;
        end
    end

    // ----------------------------------------------------------------
    // active configuration
    // ----------------------------------------------------------------
    reg [`FULL_MODE_W-1:0] active_mode_ff;
    reg active_ext_ff;
    reg factors_valid_ff;
    reg input_is_66_ff;
    reg [`IN_KHZ_W-1:0] input_khz_ff;
    reg [`FACTOR_W-1:0] comm_x2_ff;
    reg [`FACTOR_W-1:0] core_x2_ff;
    reg [`FREQ_W-1:0] comm_khz_ff;
    reg [`FREQ_W-1:0] core_khz_ff;
    reg config_valid_ff;
    reg [`FULL_MODE_W-1:0] nxt_active_mode;
    reg nxt_active_ext;
    reg nxt_factors_valid;
    reg nxt_input_is_66;
    reg [`IN_KHZ_W-1:0] nxt_input_khz;
    reg [`FACTOR_W-1:0] nxt_comm_x2;
    reg [`FACTOR_W-1:0] nxt_core_x2;
    reg [`FREQ_W-1:0] nxt_comm_khz;
    reg [`FREQ_W-1:0] nxt_core_khz;
    reg nxt_config_valid;
    wire live_basic;

    // extended modes are reported by code only; their factors are not decoded here
    assign live_basic = ~i_reset_config_select;

    // everything holds unless power-on and hard reset are low in the same cycle
    always @* begin
        nxt_active_mode = active_mode_ff;
        nxt_active_ext = active_ext_ff;
        nxt_factors_valid = factors_valid_ff;
        nxt_input_is_66 = input_is_66_ff;
        nxt_input_khz = input_khz_ff;
        nxt_comm_x2 = comm_x2_ff;
        nxt_core_x2 = core_x2_ff;
        nxt_comm_khz = comm_khz_ff;
        nxt_core_khz = core_khz_ff;
        nxt_config_valid = config_valid_ff;
        if (load_now) begin
            nxt_active_mode = live_mode;
            nxt_active_ext = i_reset_config_select;
            nxt_factors_valid = live_basic;
            nxt_config_valid = 1'b1;
            // zeros rather than a stale basic setup once an extended code is applied
            nxt_input_is_66 = 1'b0;
            nxt_input_khz = `RST_IN_KHZ;
            nxt_comm_x2 = `RST_FACTOR;
            nxt_core_x2 = `RST_FACTOR;
            nxt_comm_khz = `RST_FREQ;
            nxt_core_khz = `RST_FREQ;
            if (live_basic) begin
                nxt_input_is_66 = live_is_66;
                nxt_input_khz = live_khz;
                nxt_comm_x2 = live_comm_x2;
                nxt_core_x2 = live_core_x2;
                nxt_comm_khz = scaled_khz(live_khz, live_comm_x2);
                nxt_core_khz = scaled_khz(live_khz, live_core_x2);
            end
        end
    end

    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            active_mode_ff <= `RST_FULL_MODE;
            active_ext_ff <= 1'b0;
            factors_valid_ff <= 1'b0;
            input_is_66_ff <= 1'b0;
            input_khz_ff <= `RST_IN_KHZ;
            comm_x2_ff <= `RST_FACTOR;
            core_x2_ff <= `RST_FACTOR;
            comm_khz_ff <= `RST_FREQ;
            core_khz_ff <= `RST_FREQ;
            config_valid_ff <= 1'b0;
        end else begin
            active_mode_ff <= nxt_active_mode;
            active_ext_ff <= nxt_active_ext;
            factors_valid_ff <= nxt_factors_valid;
            input_is_66_ff <= nxt_input_is_66;
            input_khz_ff <= nxt_input_khz;
            comm_x2_ff <= nxt_comm_x2;
            core_x2_ff <= nxt_core_x2;
            comm_khz_ff <= nxt_comm_khz;
            core_khz_ff <= nxt_core_khz;
            config_valid_ff <= nxt_config_valid;
        end
    end

    // ----------------------------------------------------------------
    // status
    // ----------------------------------------------------------------
    reg por_seen_ff;
    reg applied_ff;
    reg pending_ff;

    // pending shows a hard reset that sampled pins which were not applied
    always @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            por_seen_ff <= 1'b0;
            applied_ff <= 1'b0;
            pending_ff <= 1'b0;
        end else begin
            por_seen_ff <= load_now;
            applied_ff <= por_seen_ff & ~load_now;
            pending_ff <= config_valid_ff & ~load_now &
                          (nxt_sampled_mode != active_mode_ff);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_active_mode = active_mode_ff;
    assign o_active_extended = active_ext_ff;
    assign o_factors_valid = factors_valid_ff;
    assign o_input_is_66 = input_is_66_ff;
    assign o_input_khz = input_khz_ff;
    assign o_comm_factor_x2 = comm_x2_ff;
    assign o_core_factor_x2 = core_x2_ff;
    assign o_comm_khz = comm_khz_ff;
    assign o_core_khz = core_khz_ff;
    assign o_sampled_mode = sampled_mode_ff;
    assign o_change_pending = pending_ff;
    assign o_config_valid = config_valid_ff;
    assign o_config_applied = applied_ff;

endmodule

`default_nettype wire

// ==== logic/reset_clock_mode_decoder_consts.vh ====
`ifndef RESET_CLOCK_MODE_DECODER_CONSTS_VH
`define RESET_CLOCK_MODE_DECODER_CONSTS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define MODE_W 3
`define MODE_HI_W 4
`define FULL_MODE_W 7
`define FACTOR_W 5
`define IN_KHZ_W 17
`define FREQ_W 20
`define PROD_W 22

// ----------------------------------------------------------------
// input clock classes (bit 2 of the mode code picks the class)
// ----------------------------------------------------------------
`define MODE_CLASS_BIT 2
`define MODE_COMM_BIT 1
`define MODE_CORE_BIT 0
`define IN_KHZ_33 17'h08235
`define IN_KHZ_66 17'h1046a

// ----------------------------------------------------------------
// multiplication factors, held as twice the factor
// ----------------------------------------------------------------
`define COMM_X2_33_LO 5'h06
`define COMM_X2_33_HI 5'h08
`define COMM_X2_66_LO 5'h04
`define COMM_X2_66_HI 5'h05
`define CORE_X2_33_LO 5'h08
`define CORE_X2_33_HI 5'h0a
`define CORE_X2_66_LO 5'h05
`define CORE_X2_66_HI 5'h06

// ----------------------------------------------------------------
// reset values of the active configuration
// ----------------------------------------------------------------
`define RST_MODE 3'h0
`define RST_MODE_HI 4'h0
`define RST_FULL_MODE 7'h00
`define RST_FACTOR 5'h00
`define RST_IN_KHZ 17'h00000
`define RST_FREQ 20'h00000

`endif

// ==== test/reset_clock_mode_decoder_monitor.sv ====
`default_nettype none
module reset_clock_mode_decoder_monitor (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_por_n,
    input wire logic i_hard_reset_in_n,
    input wire logic i_reset_config_select,
    input wire logic [2:0] i_clock_mode_select_pins,
    input wire logic [3:0] i_cfg_word_mode_bits,
    input wire logic [6:0] o_active_mode,
    input wire logic o_active_extended,
    input wire logic o_factors_valid,
    input wire logic o_input_is_66,
    input wire logic [16:0] o_input_khz,
    input wire logic [4:0] o_comm_factor_x2,
    input wire logic [4:0] o_core_factor_x2,
    input wire logic [19:0] o_comm_khz,
    input wire logic [19:0] o_core_khz,
    input wire logic [6:0] o_sampled_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // strap relations
    // ----------------
    wire load = !i_por_n && !i_hard_reset_in_n;
    wire [6:0] live = {i_reset_config_select ? i_cfg_word_mode_bits : 4'h0,
                       i_clock_mode_select_pins};
    wire [21:0] comm_p = o_input_khz * o_comm_factor_x2;
    wire [21:0] core_p = o_input_khz * o_core_factor_x2;
    wire [2:0] m = o_active_mode[2:0];
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    AST_SAMPLE: assert property (!i_hard_reset_in_n |=> o_sampled_mode == $past(live))
        else $error("sampled code does not follow the straps");
    AST_LOAD: assert property (load |=> o_active_mode == $past(live))
        else $error("active code not loaded");
    AST_HOLD: assert property (!load |=> $stable(o_active_mode) && $stable(o_comm_khz))
        else $error("active setup moved without power-on load");
    AST_COMM: assert property (o_factors_valid |-> o_comm_factor_x2 ==
        (m[2] ? (m[1] ? 5'h05 : 5'h04) : (m[1] ? 5'h08 : 5'h06)))
        else $error("comm processor factor wrong");
    AST_CORE: assert property (o_factors_valid |-> o_core_factor_x2 ==
        (m[2] ? (m[0] ? 5'h06 : 5'h05) : (m[0] ? 5'h0a : 5'h08)))
        else $error("core factor wrong");
    AST_CLASS: assert property (o_factors_valid |-> o_input_is_66 == m[2] &&
        o_input_khz == (m[2] ? 17'h1046a : 17'h08235))
        else $error("input class wrong");
    AST_FREQ: assert property (o_factors_valid |-> o_comm_khz == comm_p[20:1] &&
        o_core_khz == core_p[20:1])
        else $error("derived frequency wrong");
    AST_EXT: assert property (o_active_extended |-> !o_factors_valid && o_comm_khz == 20'h00000)
        else $error("extended mode reports factors");
    cover property (load ##1 !load);
    cover property (!i_hard_reset_in_n && i_por_n);
    cover property (o_active_extended);
endmodule
bind reset_clock_mode_decoder reset_clock_mode_decoder_monitor mon (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_por_n(i_por_n), .i_hard_reset_in_n(i_hard_reset_in_n),
    .i_reset_config_select(i_reset_config_select),
    .i_clock_mode_select_pins(i_clock_mode_select_pins),
    .i_cfg_word_mode_bits(i_cfg_word_mode_bits), .o_active_mode(o_active_mode),
    .o_active_extended(o_active_extended), .o_factors_valid(o_factors_valid),
    .o_input_is_66(o_input_is_66), .o_input_khz(o_input_khz),
    .o_comm_factor_x2(o_comm_factor_x2), .o_core_factor_x2(o_core_factor_x2),
    .o_comm_khz(o_comm_khz), .o_core_khz(o_core_khz), .o_sampled_mode(o_sampled_mode));
`default_nettype wire

// ==== test/reset_clock_mode_decoder_tb.sv ====
`default_nettype none
module reset_clock_mode_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, por_n, hard_n, sel, ext, fv, i66, pend, cval, appl;
    logic [2:0] pins;
    logic [3:0] bits;
    logic [6:0] act, smp;
    logic [16:0] khz;
    logic [4:0] cx, kx;
    logic [19:0] cf, kf;
    int n_errors = 0;
    int n_compared = 0;
    strap_model sm (.i_clk_sys(clk), .o_por_n(por_n), .o_hard_n(hard_n), .o_cfg_sel(sel),
        .o_pins(pins), .o_bits(bits));
    reset_clock_mode_decoder dut (.i_clk_sys(clk), .i_rstn(rstn), .i_por_n(por_n),
        .i_hard_reset_in_n(hard_n), .i_reset_config_select(sel),
        .i_clock_mode_select_pins(pins), .i_cfg_word_mode_bits(bits), .o_active_mode(act),
        .o_active_extended(ext), .o_factors_valid(fv), .o_input_is_66(i66),
        .o_input_khz(khz), .o_comm_factor_x2(cx), .o_core_factor_x2(kx), .o_comm_khz(cf),
        .o_core_khz(kf), .o_sampled_mode(smp), .o_change_pending(pend),
        .o_config_valid(cval), .o_config_applied(appl));
    // ----------------
    // checking
    // ----------------
    task automatic check(input string what, input logic [21:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_basic();
        logic [2:0] c;
        logic [16:0] k;
        logic [4:0] ex, ek;
        int n;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            k = c[2] ? 17'h1046a : 17'h08235;
            ex = c[2] ? (c[1] ? 5'h05 : 5'h04) : (c[1] ? 5'h08 : 5'h06);
            ek = c[2] ? (c[0] ? 5'h06 : 5'h05) : (c[0] ? 5'h0a : 5'h08);
            sm.drive(1'b0, 1'b0, 1'b0, c, 4'hf);
            sm.drive(1'b1, 1'b1, 1'b0, c, 4'hf);
            #1;
            check("mode", act, {4'h0, c});
            check("valid", {fv, cval, i66}, {2'b11, c[2]});
            check("khz", khz, k);
            check("comm", cx, ex);
            check("core", kx, ek);
            check("comm_khz", cf, 22'(({5'h00, k} * ex) >> 1));
            check("core_khz", kf, 22'(({5'h00, k} * ek) >> 1));
            n = 0;
            repeat (4) begin
                @(posedge clk);
                #1;
                n += int'(appl === 1'b1);
            end
            check("applied", 22'(n), 22'h000001);
        end
    endtask
    task automatic t_hard_only();
        sm.drive(1'b1, 1'b0, 1'b0, 3'h2, 4'h0);
        sm.drive(1'b1, 1'b1, 1'b0, 3'h2, 4'h0);
        #1;
        check("sampled", smp, 7'h02);
        check("kept", act, 7'h07);
        check("pending", pend, 1'b1);
        sm.drive(1'b0, 1'b1, 1'b0, 3'h0, 4'h0);
        sm.drive(1'b1, 1'b1, 1'b0, 3'h0, 4'h0);
        #1;
        check("por alone", act, 7'h07);
    endtask
    task automatic t_ext();
        sm.drive(1'b0, 1'b0, 1'b1, 3'h2, 4'h1);
        sm.drive(1'b1, 1'b1, 1'b1, 3'h2, 4'h1);
        #1;
        check("ext mode", act, 7'h0a);
        check("ext flags", {ext, fv}, 2'b10);
        check("ext comm_khz", cf, 20'h00000);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #40000;
        n_errors++;
        wrap_up();
    end
    initial begin
        rstn = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_basic();
        t_hard_only();
        t_ext();
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== test/strap_model.sv ====
`default_nettype none
module strap_model (
    input wire logic i_clk_sys,
    output var logic o_por_n,
    output var logic o_hard_n,
    output var logic o_cfg_sel,
    output var logic [2:0] o_pins,
    output var logic [3:0] o_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // board straps
    // ----------------
    initial begin
        o_por_n = 1'b1;
        o_hard_n = 1'b1;
        o_cfg_sel = 1'b0;
        o_pins = 3'h0;
        o_bits = 4'h0;
    end
    // straps settle just after an edge so the block sees them a full cycle
    task automatic drive(input logic por, hard, sel, input logic [2:0] p, input logic [3:0] b);
        @(posedge i_clk_sys);
        o_por_n <= por;
        o_hard_n <= hard;
        o_cfg_sel <= sel;
        o_pins <= p;
        o_bits <= b;
    endtask
endmodule
`default_nettype wire
